// file: logic/rsp_pkg.sv
package rsp_pkg;
    // register indices as printed; byte address is four times the index
    localparam logic [7:0] IDX_RST = 8'hb1;
    localparam logic [7:0] IDX_POWER_CONTROL_REGISTER = 8'h87;
    localparam logic [7:0] IDX_SUSPEND_LOCK_REGISTER = 8'h8e;
    localparam logic [11:0] ADDR_RST = {2'h0, IDX_RST, 2'h0};
    localparam logic [11:0] ADDR_POWER_CONTROL_REGISTER = {2'h0, IDX_POWER_CONTROL_REGISTER, 2'h0};
    localparam logic [11:0] ADDR_SUSPEND_LOCK_REGISTER = {2'h0, IDX_SUSPEND_LOCK_REGISTER, 2'h0};

    // reset cause and watchdog period field positions
    localparam int BIT_WDOG_FLAG = 7;
    localparam int BIT_POR_FLAG = 5;
    localparam int BIT_LV_FLAG = 4;
    localparam logic [2:0] PERIOD_RESET = 3'h0;
    localparam logic POR_FLAG_RESET = 1'h1;

    // power control field positions
    localparam int BIT_PD_REQ = 1;
    localparam int BIT_IDLE_REQ = 0;
    localparam int BIT_POWER_CONTROL_REGISTER_RSVD = 4;
    localparam logic [7:0] POWER_CONTROL_REGISTER_RESET = 8'h00;
    localparam logic [7:0] SUSPEND_LOCK_REGISTER_RESET = 8'h00;
    localparam logic [7:0] LOCK_KEY = 8'h55;

    // clock source options with a single clock
    localparam logic [3:0] OSC_SINGLE_A = 4'h0;
    localparam logic [3:0] OSC_SINGLE_B = 4'he;

    // minimum watchdog overflow periods in ms, per select code
    localparam logic [12:0] WDT_MS_0 = 13'd4096;
    localparam logic [12:0] WDT_MS_1 = 13'd1024;
    localparam logic [12:0] WDT_MS_2 = 13'd256;
    localparam logic [12:0] WDT_MS_3 = 13'd128;
    localparam logic [12:0] WDT_MS_4 = 13'd64;
    localparam logic [12:0] WDT_MS_5 = 13'd16;
    localparam logic [12:0] WDT_MS_6 = 13'd4;
    localparam logic [12:0] WDT_MS_7 = 13'd1;

    // oscillator warm-up length in pclk cycles
    localparam int WARMUP_CYCLES = 256;

    typedef enum logic [1:0] {
        MODE_RUN = 2'b00,
        MODE_IDLE = 2'b01,
        MODE_PDOWN = 2'b10,
        MODE_WARM = 2'b11
    } rsp_mode_t;

    // reset events, one-cycle pulses
    typedef struct packed {
        logic pin;
        logic watchdog;
        logic code_range;
        logic low_voltage;
    } rsp_rst_ev_t;

    // clock gate enables
    typedef struct packed {
        logic cpu;
        logic periph;
        logic timer3_lf;
        logic osc;
        logic wdt;
    } rsp_clk_en_t;
endpackage

// file: logic/rsp_warmup.sv
`timescale 1ns/1ps
`default_nettype none
module rsp_warmup
    import rsp_pkg::*;
#(
    parameter int CYCLES = WARMUP_CYCLES
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic start,
    output logic done
);
    logic [15:0] count;
    logic running;

    // counts down from start, pulses done at the end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= 16'h0000;
            running <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                count <= 16'(CYCLES - 1);
                running <= 1'b1;
            end else if (running) begin
                if (count == 16'h0000) begin
                    running <= 1'b0;
                    done <= 1'b1;
                end else begin
                    count <= count - 16'h0001;
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: logic/rsp_reset_power.sv
`timescale 1ns/1ps
`default_nettype none
module rsp_reset_power
    import rsp_pkg::*;
(
    // clock and power-on reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // reset events other than power-on
    input wire rsp_rst_ev_t rst_ev,
    // wake-up sources
    input wire logic irq_any,
    input wire logic ext_irq_wake,
    input wire logic timer3_irq,
    input wire logic timer3_lf_source,
    // options
    input wire logic [3:0] clock_source_option,
    input wire logic sysclk_is_lf,
    input wire logic watchdog_enable_option,
    // status and control out
    output rsp_clk_en_t clk_en,
    output rsp_mode_t mode,
    output logic wdt_restart,
    output logic cpu_reset,
    output logic wake_service,
    output logic [12:0] watchdog_min_period_ms
);
    logic watchdog_reset_flag;
    logic power_on_flag;
    logic low_voltage_flag;
    logic [2:0] watchdog_period_select;
    logic [7:0] power_control_register;
    logic [7:0] suspend_lock_register;
    logic lock_armed;
    logic clr_lock;
    logic clr_req;
    logic warm_for_reset;
    logic warm_from_idle;
    logic warm_start;
    logic warm_done;
    logic access;
    logic wr_rst;
    logic wr_power_control_register;
    logic wr_suspend_lock_register;
    logic soft_rst;
    logic req_bits;
    logic enter;
    logic pd_wake;
    logic single_clk;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] reg_addr);
        hit = (a == reg_addr);
    endfunction

    function automatic logic [12:0] period_ms(input logic [2:0] sel);
        case (sel)
            3'h0: period_ms = WDT_MS_0;
            3'h1: period_ms = WDT_MS_1;
            3'h2: period_ms = WDT_MS_2;
            3'h3: period_ms = WDT_MS_3;
            3'h4: period_ms = WDT_MS_4;
            3'h5: period_ms = WDT_MS_5;
            3'h6: period_ms = WDT_MS_6;
            default: period_ms = WDT_MS_7;
        endcase
    endfunction

    // decode of completed transfers and events
    assign access = psel & penable & pready;
    assign wr_rst = access & pwrite & hit(paddr, ADDR_RST);
    assign wr_power_control_register = access & pwrite & hit(paddr, ADDR_POWER_CONTROL_REGISTER);
    assign wr_suspend_lock_register = access & pwrite & hit(paddr, ADDR_SUSPEND_LOCK_REGISTER);
    assign soft_rst = rst_ev.pin | rst_ev.watchdog | rst_ev.code_range | rst_ev.low_voltage;
    assign req_bits = pwdata[BIT_PD_REQ] | pwdata[BIT_IDLE_REQ];
    assign enter = wr_power_control_register & lock_armed & req_bits & (mode == MODE_RUN);
    assign pd_wake = ext_irq_wake | (timer3_irq & timer3_lf_source);
    assign single_clk = (clock_source_option == OSC_SINGLE_A) || (clock_source_option == OSC_SINGLE_B);

    // apb answer: one wait state, read data and error registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel & penable & ~pready;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            if (psel & penable & ~pready) begin
                if (hit(paddr, ADDR_RST)) begin
                    prdata[BIT_WDOG_FLAG] <= watchdog_reset_flag;
                    prdata[BIT_POR_FLAG] <= power_on_flag;
                    prdata[BIT_LV_FLAG] <= low_voltage_flag;
                    prdata[2:0] <= watchdog_period_select;
                end else if (hit(paddr, ADDR_POWER_CONTROL_REGISTER)) begin
                    prdata[7:0] <= power_control_register;
                end else if (hit(paddr, ADDR_SUSPEND_LOCK_REGISTER)) begin
                    prdata[7:0] <= suspend_lock_register;
                end else begin
                    pslverr <= 1'b1;
                end
            end
        end
    end

    // reset cause flags: hardware set beats software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watchdog_reset_flag <= 1'b0;
            power_on_flag <= POR_FLAG_RESET;
            low_voltage_flag <= 1'b0;
        end else begin
            if (rst_ev.watchdog | rst_ev.code_range) begin
                watchdog_reset_flag <= 1'b1;
            end else if (wr_rst & ~pwdata[BIT_WDOG_FLAG]) begin
                watchdog_reset_flag <= 1'b0;
            end
            if (wr_rst & ~pwdata[BIT_POR_FLAG]) begin
                power_on_flag <= 1'b0;
            end
            if (rst_ev.low_voltage) begin
                low_voltage_flag <= 1'b1;
            end else if (wr_rst & ~pwdata[BIT_LV_FLAG]) begin
                low_voltage_flag <= 1'b0;
            end
        end
    end

    // watchdog period select and its decoded minimum period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watchdog_period_select <= PERIOD_RESET;
            watchdog_min_period_ms <= WDT_MS_0;
        end else begin
            if (soft_rst) begin
                watchdog_period_select <= PERIOD_RESET;
            end else if (wr_rst) begin
                watchdog_period_select <= pwdata[2:0];
            end
            watchdog_min_period_ms <= period_ms(watchdog_period_select);
        end
    end

    // watchdog restart on any reset cause register access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_restart <= 1'b0;
        end else begin
            wdt_restart <= access & hit(paddr, ADDR_RST);
        end
    end

    // lock sequence tracking: armed only right after the key write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_armed <= 1'b0;
            clr_lock <= 1'b0;
            clr_req <= 1'b0;
        end else begin
            clr_lock <= 1'b0;
            clr_req <= 1'b0;
            if (access) begin
                lock_armed <= wr_suspend_lock_register & (pwdata[7:0] == LOCK_KEY);
                clr_lock <= ~(wr_suspend_lock_register & (pwdata[7:0] == LOCK_KEY)) & ~enter;
                clr_req <= wr_power_control_register & req_bits & ~enter;
            end
        end
    end

    // suspend lock register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            suspend_lock_register <= SUSPEND_LOCK_REGISTER_RESET;
        end else if (soft_rst) begin
            suspend_lock_register <= SUSPEND_LOCK_REGISTER_RESET;
        end else if (warm_done & ~warm_for_reset) begin
            suspend_lock_register <= SUSPEND_LOCK_REGISTER_RESET;
        end else if (wr_suspend_lock_register) begin
            suspend_lock_register <= pwdata[7:0];
        end else if (clr_lock) begin
            suspend_lock_register <= SUSPEND_LOCK_REGISTER_RESET;
        end
    end

    // power control register; request bits cleared by hardware
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_control_register <= POWER_CONTROL_REGISTER_RESET;
        end else if (soft_rst) begin
            power_control_register <= POWER_CONTROL_REGISTER_RESET;
        end else if (warm_done & ~warm_for_reset) begin
            power_control_register[BIT_PD_REQ] <= 1'b0;
            power_control_register[BIT_IDLE_REQ] <= 1'b0;
        end else if (wr_power_control_register) begin
            power_control_register <= pwdata[7:0];
            power_control_register[BIT_POWER_CONTROL_REGISTER_RSVD] <= 1'b0;
        end else if (clr_req) begin
            power_control_register[BIT_PD_REQ] <= 1'b0;
            power_control_register[BIT_IDLE_REQ] <= 1'b0;
        end
    end

    // low-power mode sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= MODE_RUN;
            warm_for_reset <= 1'b0;
            warm_from_idle <= 1'b0;
            warm_start <= 1'b0;
            cpu_reset <= 1'b0;
            wake_service <= 1'b0;
        end else begin
            warm_start <= 1'b0;
            cpu_reset <= 1'b0;
            wake_service <= 1'b0;
            case (mode)
                MODE_RUN: begin
                    if (soft_rst) begin
                        cpu_reset <= 1'b1;
                    end else if (enter) begin
                        if (pwdata[BIT_PD_REQ]) begin
                            mode <= MODE_PDOWN;
                        end else begin
                            mode <= MODE_IDLE;
                        end
                    end
                end
                MODE_IDLE: begin
                    if (soft_rst) begin
                        mode <= MODE_RUN;
                        cpu_reset <= 1'b1;
                    end else if (irq_any) begin
                        mode <= MODE_WARM;
                        warm_for_reset <= 1'b0;
                        warm_from_idle <= 1'b1;
                        warm_start <= 1'b1;
                    end
                end
                MODE_PDOWN: begin
                    if (soft_rst | pd_wake) begin
                        mode <= MODE_WARM;
                        warm_for_reset <= soft_rst;
                        warm_from_idle <= 1'b0;
                        warm_start <= 1'b1;
                    end
                end
                default: begin
                    if (soft_rst) begin
                        warm_for_reset <= 1'b1;
                    end
                    if (warm_done) begin
                        mode <= MODE_RUN;
                        cpu_reset <= warm_for_reset | soft_rst;
                        wake_service <= ~(warm_for_reset | soft_rst);
                    end
                end
            endcase
        end
    end

    // clock gates follow the mode; the watchdog gate follows watchdog_enable_option
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_en <= '{cpu: 1'b1, periph: 1'b1, timer3_lf: 1'b1, osc: 1'b1, wdt: 1'b0};
        end else begin
            clk_en.wdt <= watchdog_enable_option;
            case (mode)
                MODE_RUN: begin
                    clk_en.cpu <= 1'b1;
                    clk_en.periph <= 1'b1;
                    clk_en.timer3_lf <= 1'b1;
                    clk_en.osc <= 1'b1;
                end
                MODE_IDLE: begin
                    clk_en.cpu <= 1'b0;
                    clk_en.periph <= 1'b1;
                    clk_en.timer3_lf <= 1'b1;
                    clk_en.osc <= 1'b1;
                end
                MODE_PDOWN: begin
                    clk_en.cpu <= 1'b0;
                    clk_en.periph <= 1'b0;
                    clk_en.timer3_lf <= ~single_clk & ~sysclk_is_lf;
                    clk_en.osc <= 1'b0;
                end
                default: begin
                    clk_en.cpu <= 1'b0;
                    clk_en.periph <= warm_from_idle;
                    clk_en.timer3_lf <= 1'b1;
                    clk_en.osc <= 1'b1;
                end
            endcase
        end
    end

    rsp_warmup #(
        .CYCLES(WARMUP_CYCLES)
    ) u_warmup (
        .pclk(pclk),
        .presetn(presetn),
        .start(warm_start),
        .done(warm_done)
    );

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    wdog_flag_set_a: assert property (
        (rst_ev.watchdog | rst_ev.code_range) |=> watchdog_reset_flag)
        else $error("watchdog flag not set by its reset");
    wdog_flag_clr_a: assert property (
        (wr_rst & ~pwdata[BIT_WDOG_FLAG] & ~rst_ev.watchdog & ~rst_ev.code_range) |=> !watchdog_reset_flag)
        else $error("watchdog flag not cleared by zero write");
    por_flag_only_sw_a: assert property (
        $fell(power_on_flag) |-> $past(wr_rst) && !$past(pwdata[BIT_POR_FLAG]))
        else $error("power-on flag cleared without software");
    lv_flag_hold_a: assert property (
        (soft_rst & ~rst_ev.low_voltage & ~wr_rst) |=> $stable(low_voltage_flag))
        else $error("low-voltage flag changed by other reset");
    write_one_ign_a: assert property (
        (wr_rst & pwdata[BIT_WDOG_FLAG] & !watchdog_reset_flag & ~rst_ev.watchdog & ~rst_ev.code_range)
        |=> !watchdog_reset_flag)
        else $error("write of one set watchdog flag");
    period_reset_a: assert property (
        soft_rst |=> watchdog_period_select == PERIOD_RESET ##1 watchdog_min_period_ms == WDT_MS_0)
        else $error("period field not reset");
    idle_clocks_a: assert property (
        (mode == MODE_IDLE) |=> (!clk_en.cpu && clk_en.periph))
        else $error("idle clock gating wrong");
    idle_enter_a: assert property (
        (enter & ~pwdata[BIT_PD_REQ] & ~soft_rst) |=> mode == MODE_IDLE)
        else $error("armed idle request did not enter idle");
    no_unlocked_a: assert property (
        (mode == MODE_RUN & wr_power_control_register & req_bits & ~lock_armed & ~soft_rst)
        |=> mode == MODE_RUN ##1 (power_control_register[1:0] == 2'b00 || wr_power_control_register))
        else $error("unlocked request not refused");
    pd_priority_a: assert property (
        (enter & pwdata[BIT_PD_REQ] & pwdata[BIT_IDLE_REQ] & ~soft_rst) |=> mode == MODE_PDOWN)
        else $error("power-down did not win over idle");
    idle_rst_a: assert property (
        (mode == MODE_IDLE & soft_rst) |=> (cpu_reset && mode == MODE_RUN && suspend_lock_register == 8'h00))
        else $error("reset in idle not handled");
    pd_single_a: assert property (
        (mode == MODE_PDOWN & single_clk) |=> (!clk_en.cpu && !clk_en.periph && !clk_en.timer3_lf))
        else $error("single clock power-down left a clock on");
    pd_dual_hf_a: assert property (
        (mode == MODE_PDOWN & ~single_clk & ~sysclk_is_lf) |=> clk_en.timer3_lf)
        else $error("timer3 slow clock stopped in power-down");
    pd_wdt_run_a: assert property (
        (mode == MODE_PDOWN) |=> clk_en.wdt == $past(watchdog_enable_option))
        else $error("watchdog clock not kept in power-down");
    t3_wake_gate_a: assert property (
        (mode == MODE_PDOWN & timer3_irq & ~timer3_lf_source & ~ext_irq_wake & ~soft_rst) |=> mode == MODE_PDOWN)
        else $error("timer3 woke without slow clock");
    pd_rst_warm_a: assert property (
        (mode == MODE_PDOWN & soft_rst) |=> (mode == MODE_WARM && !cpu_reset) ##1 !clk_en.cpu)
        else $error("reset in power-down skipped warm-up");
    wake_clears_a: assert property (
        $rose(wake_service) |-> (suspend_lock_register == 8'h00 && power_control_register[1:0] == 2'b00))
        else $error("wake left lock or request set");
    wdt_touch_a: assert property (
        (access & hit(paddr, ADDR_RST)) |=> wdt_restart)
        else $error("watchdog not restarted on access");

    enter_idle_c: cover property (enter ##1 mode == MODE_IDLE);
    enter_pd_c: cover property (enter ##1 mode == MODE_PDOWN);
    wake_c: cover property (wake_service);
    pd_reset_c: cover property (mode == MODE_WARM && warm_for_reset && warm_done);
endmodule
`default_nettype wire

// file: test/rsp_reset_power_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rsp_reset_power_tb
    import rsp_pkg::*;
;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rst_hit = 0;
    logic irq_any = 0, ext_irq_wake = 0, timer3_irq = 0, timer3_lf_source = 0;
    logic sysclk_is_lf = 0, watchdog_enable_option = 1;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic [3:0] clock_source_option = 0;
    rsp_rst_ev_t rst_ev = '0;
    logic pready, pslverr, wdt_restart, cpu_reset, wake_service;
    rsp_clk_en_t clk_en;
    rsp_mode_t mode;
    logic [12:0] watchdog_min_period_ms;
    int failures = 0, tests_run = 0, cycles = 0, waited = 0, k = 0;
    logic [32:0] exp_q[$];
    logic [12:0] ms_tab[8] = '{13'd4096, 13'd1024, 13'd256, 13'd128, 13'd64, 13'd16, 13'd4, 13'd1};
    logic [3:0] ev_tab[4] = '{4'h2, 4'h1, 4'h8, 4'h4};
    logic [7:0] ev_exp[4] = '{8'h80, 8'h90, 8'h90, 8'h80};

    rsp_reset_power dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rst_ev(rst_ev),
        .irq_any(irq_any), .ext_irq_wake(ext_irq_wake), .timer3_irq(timer3_irq),
        .timer3_lf_source(timer3_lf_source), .clock_source_option(clock_source_option),
        .sysclk_is_lf(sysclk_is_lf), .watchdog_enable_option(watchdog_enable_option), .clk_en(clk_en),
        .mode(mode), .wdt_restart(wdt_restart), .cpu_reset(cpu_reset), .wake_service(wake_service),
        .watchdog_min_period_ms(watchdog_min_period_ms));

    // 50 mhz clock
    initial begin
        forever #10 pclk = ~pclk;
    end

    task check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // one apb transfer, held until pready is seen high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 0;
        penable <= 0;
    endtask

    task rd(input logic [11:0] a, input logic err, input logic [31:0] exp);
        exp_q.push_back({err, exp});
        apb(0, a, 0);
    endtask

    task wait_mode(input rsp_mode_t m);
        waited = 0;
        while (mode !== m && waited < 400) begin
            @(posedge pclk);
            waited++;
        end
    endtask

    task pulse(input logic [3:0] ev);
        @(posedge pclk) rst_ev <= ev;
        @(posedge pclk) rst_ev <= '0;
    endtask

    task enter(input logic [7:0] req, input rsp_mode_t m);
        apb(1, ADDR_SUSPEND_LOCK_REGISTER, LOCK_KEY);
        apb(1, ADDR_POWER_CONTROL_REGISTER, {24'h0, req});
        wait_mode(m);
        repeat (3) @(posedge pclk);
    endtask

    // read data checker and watchdog restart watcher
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
            check("pslverr", pslverr, exp_q[0][32]);
            check("prdata", prdata, exp_q[0][31:0]);
            void'(exp_q.pop_front());
        end
        if (rst_hit) check("wdt_restart", wdt_restart, 1);
        rst_hit <= psel && penable && pready === 1'b1 && paddr == ADDR_RST;
    end

    // hang guard
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            print_verdict();
        end
    end

    initial begin
        k = $urandom(32'h06e62900);
        repeat (3) @(posedge pclk);
        presetn <= 1;
        rd(ADDR_RST, 0, 32'h20);
        apb(1, ADDR_RST, 32'h0);
        rd(ADDR_RST, 0, 32'h00);
        for (k = 0; k < 8; k++) begin
            apb(1, ADDR_RST, {$urandom} & 32'hfffffff8 | k);
            repeat (2) @(posedge pclk);
            check("period", watchdog_min_period_ms, ms_tab[k]);
            rd(ADDR_RST, 0, k);
        end
        rd(12'h004, 1, 32'h0);
        $display("register test done");
        for (k = 0; k < 4; k++) begin
            if (k == 3) apb(1, ADDR_RST, 32'h0);
            pulse(ev_tab[k]);
            rd(ADDR_RST, 0, ev_exp[k]);
        end
        $display("reset cause test done");
        apb(1, ADDR_SUSPEND_LOCK_REGISTER, LOCK_KEY);
        rd(ADDR_RST, 0, 32'h80);
        apb(1, ADDR_POWER_CONTROL_REGISTER, 32'h1);
        repeat (3) @(posedge pclk);
        check("mode", mode, MODE_RUN);
        rd(ADDR_POWER_CONTROL_REGISTER, 0, 32'h0);
        rd(ADDR_SUSPEND_LOCK_REGISTER, 0, 32'h0);
        enter(8'h01, MODE_IDLE);
        check("mode", mode, MODE_IDLE);
        check("cpu clock", clk_en.cpu, 0);
        check("periph clock", clk_en.periph, 1);
        irq_any <= 1;
        wait_mode(MODE_RUN);
        check("wake service", wake_service, 1);
        irq_any <= 0;
        check("warm length", waited >= WARMUP_CYCLES, 1);
        rd(ADDR_POWER_CONTROL_REGISTER, 0, 32'h0);
        rd(ADDR_SUSPEND_LOCK_REGISTER, 0, 32'h0);
        $display("idle test done");
        enter(8'h03, MODE_PDOWN);
        check("mode", mode, MODE_PDOWN);
        check("clocks", {clk_en.periph, clk_en.timer3_lf, clk_en.wdt}, 3'b001);
        check("osc clock", clk_en.osc, 0);
        timer3_irq <= 1;
        repeat (10) @(posedge pclk);
        check("mode", mode, MODE_PDOWN);
        ext_irq_wake <= 1;
        wait_mode(MODE_RUN);
        check("wake service", wake_service, 1);
        ext_irq_wake <= 0;
        check("warm length", waited >= WARMUP_CYCLES, 1);
        rd(ADDR_POWER_CONTROL_REGISTER, 0, 32'h0);
        clock_source_option <= 4'h3;
        enter(8'h02, MODE_PDOWN);
        check("clocks", {clk_en.periph, clk_en.timer3_lf}, 2'b01);
        timer3_lf_source <= 1;
        wait_mode(MODE_RUN);
        timer3_irq <= 0;
        timer3_lf_source <= 0;
        check("mode", mode, MODE_RUN);
        sysclk_is_lf <= 1;
        enter(8'h02, MODE_PDOWN);
        check("lf clock", clk_en.timer3_lf, 0);
        pulse(4'h8);
        wait_mode(MODE_WARM);
        repeat (2) @(posedge pclk);
        check("cpu clock", clk_en.cpu, 0);
        wait_mode(MODE_RUN);
        check("cpu reset", cpu_reset, 1);
        check("no wake service", wake_service, 0);
        check("mode", mode, MODE_RUN);
        rd(ADDR_POWER_CONTROL_REGISTER, 0, 32'h0);
        rd(ADDR_SUSPEND_LOCK_REGISTER, 0, 32'h0);
        $display("power-down test done");
        repeat (3) @(posedge pclk);
        print_verdict();
    end
endmodule
`default_nettype wire
